//--- shared/igss_pkg.sv
// Package with offsets, reset values and flag groupings for the summary status block
package igss_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] INTERRUPT_GROUP_SUMMARY_OFS = 8'h00;
    localparam logic [DATA_W-1:0] INTERRUPT_GROUP_SUMMARY_RST = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ_VAL = 8'h00;

    localparam int POWER_GROUP_SUMMARY_BIT = 0;
    localparam int AMPLIFIER_GROUP_SUMMARY_BIT = 1;
    localparam int CONVERTER_GROUP_SUMMARY_BIT = 2;
    localparam int PEAK_GROUP_SUMMARY_BIT = 3;
    localparam int IMPEDANCE_GROUP_SUMMARY_BIT = 4;
    localparam int DRIVER_GROUP_SUMMARY_BIT = 5;
    localparam int PIN_INPUT_GROUP_SUMMARY_BIT = 6;
    localparam int THERMAL_GROUP_SUMMARY_BIT = 7;

    // Latched flags kept by the interrupt registers outside this block
    typedef struct packed {
        logic ldo_limit_flag;
        logic buck_limit_flag;
        logic clock_validity_flag;
        logic supply_event_flag;
        logic power_timer_event_flag;
        logic amplifier_overcurrent_flag;
        logic boost_power_good_flag;
        logic boost_current_limit_flag;
        logic boost_overvoltage_flag;
        logic comparator_a_flag;
        logic comparator_b_flag;
        logic peak_detector_one_flag;
        logic peak_detector_two_flag;
        logic peak_detector_three_flag;
        logic impedance_detect_flag;
        logic led_fault_flag;
        logic relay_fault_flag;
        logic pin_input_one_flag;
        logic pin_input_two_flag;
        logic thermal_shutdown_flag;
        logic thermal_warning_flag;
        logic amplifier_overtemp_flag;
    } igss_ext_flags_t;

    // Per-flag interrupt mask, 1 masks the flag
    typedef struct packed {
        igss_ext_flags_t ext;
        logic reset_done_flag;
        logic conversion_ready_flag;
    } igss_mask_t;

    // Pin configuration, 1 when the pin is a logic input
    typedef struct packed {
        logic pin_one_is_input;
        logic pin_two_is_input;
    } igss_pin_cfg_t;

endpackage : igss_pkg

//--- verilog/igss_summary_status.sv
// Interrupt group summary status register with two locally latched flags
module igss_summary_status (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire igss_pkg::igss_ext_flags_t ext_flags,
    input wire igss_pkg::igss_mask_t flag_mask,
    input wire igss_pkg::igss_pin_cfg_t pin_cfg,
    input wire logic reset_complete_event,
    input wire logic conversion_busy_status,
    input wire logic reset_done_clear,
    input wire logic conversion_ready_clear,
    input wire logic rd_en,
    input wire logic [igss_pkg::ADDR_W-1:0] rd_addr,
    output logic [igss_pkg::DATA_W-1:0] rd_data_r,
    output logic [igss_pkg::DATA_W-1:0] interrupt_group_summary_r,
    output logic reset_done_flag_r,
    output logic conversion_ready_flag_r,
    output logic interrupt_request_out_n_r
);

    logic reset_complete_event_r;
    logic conversion_busy_status_r;
    logic reset_done_flag_nxt;
    logic conversion_ready_flag_nxt;
    logic reset_complete_event_nxt;
    logic conversion_busy_status_nxt;
    logic [igss_pkg::DATA_W-1:0] summary_nxt;
    logic [igss_pkg::DATA_W-1:0] rd_data_nxt;
    logic interrupt_request_out_n_nxt;
    igss_pkg::igss_mask_t all_flags;

    // Rising edge of a level against its value one cycle earlier
    function automatic logic rise_seen(
        input logic level_now,
        input logic level_prev
    );
        return level_now & ~level_prev;
    endfunction : rise_seen

    function automatic logic fall_seen(
        input logic level_now,
        input logic level_prev
    );
        return ~level_now & level_prev;
    endfunction : fall_seen

    // Held flag: a set in the same cycle as a clear wins
    function automatic logic flag_next(
        input logic held,
        input logic clear,
        input logic set
    );
        logic result;
        result = held;
        if (clear) begin
            result = 1'b0;
        end
        if (set) begin
            result = 1'b1;
        end
        return result;
    endfunction : flag_next

    function automatic logic power_any(
        input igss_pkg::igss_ext_flags_t f,
        input logic reset_done
    );
        return f.ldo_limit_flag | f.buck_limit_flag | f.clock_validity_flag
            | reset_done | f.supply_event_flag | f.power_timer_event_flag;
    endfunction : power_any

    function automatic logic amplifier_any(
        input igss_pkg::igss_ext_flags_t f
    );
        return f.amplifier_overcurrent_flag | f.boost_power_good_flag
            | f.boost_current_limit_flag | f.boost_overvoltage_flag;
    endfunction : amplifier_any

    function automatic logic converter_any(
        input igss_pkg::igss_ext_flags_t f,
        input logic conv_ready
    );
        return f.comparator_a_flag | f.comparator_b_flag | conv_ready;
    endfunction : converter_any

    function automatic logic peak_any(
        input igss_pkg::igss_ext_flags_t f
    );
        return f.peak_detector_one_flag | f.peak_detector_two_flag
            | f.peak_detector_three_flag;
    endfunction : peak_any

    function automatic logic impedance_any(
        input igss_pkg::igss_ext_flags_t f
    );
        return f.impedance_detect_flag;
    endfunction : impedance_any

    function automatic logic driver_any(
        input igss_pkg::igss_ext_flags_t f
    );
        return f.led_fault_flag | f.relay_fault_flag;
    endfunction : driver_any

    // Pin flags count in the summary bit only while the pin is a logic input; the interrupt request takes them either way
    function automatic logic pin_input_any(
        input igss_pkg::igss_ext_flags_t f,
        input igss_pkg::igss_pin_cfg_t cfg
    );
        return (f.pin_input_one_flag & cfg.pin_one_is_input)
            | (f.pin_input_two_flag & cfg.pin_two_is_input);
    endfunction : pin_input_any

    function automatic logic thermal_any(
        input igss_pkg::igss_ext_flags_t f
    );
        return f.thermal_shutdown_flag | f.thermal_warning_flag
            | f.amplifier_overtemp_flag;
    endfunction : thermal_any

    function automatic logic [igss_pkg::DATA_W-1:0] summary_word(
        input igss_pkg::igss_ext_flags_t f,
        input igss_pkg::igss_pin_cfg_t cfg,
        input logic reset_done,
        input logic conv_ready
    );
        logic [igss_pkg::DATA_W-1:0] word;
        word = igss_pkg::INTERRUPT_GROUP_SUMMARY_RST;
        word[igss_pkg::POWER_GROUP_SUMMARY_BIT] = power_any(f, reset_done);
        word[igss_pkg::AMPLIFIER_GROUP_SUMMARY_BIT] = amplifier_any(f);
        word[igss_pkg::CONVERTER_GROUP_SUMMARY_BIT] = converter_any(f, conv_ready);
        word[igss_pkg::PEAK_GROUP_SUMMARY_BIT] = peak_any(f);
        word[igss_pkg::IMPEDANCE_GROUP_SUMMARY_BIT] = impedance_any(f);
        word[igss_pkg::DRIVER_GROUP_SUMMARY_BIT] = driver_any(f);
        word[igss_pkg::PIN_INPUT_GROUP_SUMMARY_BIT] = pin_input_any(f, cfg);
        word[igss_pkg::THERMAL_GROUP_SUMMARY_BIT] = thermal_any(f);
        return word;
    endfunction : summary_word

    // Unmapped addresses read as a fixed value
    function automatic logic [igss_pkg::DATA_W-1:0] read_word(
        input logic [igss_pkg::ADDR_W-1:0] addr,
        input logic [igss_pkg::DATA_W-1:0] summary
    );
        logic [igss_pkg::DATA_W-1:0] word;
        word = igss_pkg::UNMAPPED_READ_VAL;
        if (addr == igss_pkg::INTERRUPT_GROUP_SUMMARY_OFS) begin
            word = summary;
        end
        return word;
    endfunction : read_word

    // Flags latched here: set wins over a clear in the same cycle
    always_comb begin
        reset_complete_event_nxt = reset_complete_event;
        conversion_busy_status_nxt = conversion_busy_status;
        reset_done_flag_nxt = flag_next(reset_done_flag_r, reset_done_clear,
            rise_seen(reset_complete_event, reset_complete_event_r));
        conversion_ready_flag_nxt = flag_next(conversion_ready_flag_r, conversion_ready_clear,
            fall_seen(conversion_busy_status, conversion_busy_status_r));
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reset_complete_event_r <= 1'b0;
            conversion_busy_status_r <= 1'b0;
            reset_done_flag_r <= 1'b0;
            conversion_ready_flag_r <= 1'b0;
        end else begin
            reset_complete_event_r <= reset_complete_event_nxt;
            conversion_busy_status_r <= conversion_busy_status_nxt;
            reset_done_flag_r <= reset_done_flag_nxt;
            conversion_ready_flag_r <= conversion_ready_flag_nxt;
        end
    end

    // Group summaries, interrupt request and read data
    always_comb begin
        all_flags.ext = ext_flags;
        all_flags.reset_done_flag = reset_done_flag_r;
        all_flags.conversion_ready_flag = conversion_ready_flag_r;
        summary_nxt = summary_word(ext_flags, pin_cfg, reset_done_flag_r,
            conversion_ready_flag_r);
        interrupt_request_out_n_nxt = ~(|(all_flags & ~flag_mask));
        rd_data_nxt = rd_data_r;
        if (rd_en) begin
            rd_data_nxt = read_word(rd_addr, summary_nxt);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_group_summary_r <= igss_pkg::INTERRUPT_GROUP_SUMMARY_RST;
            rd_data_r <= igss_pkg::INTERRUPT_GROUP_SUMMARY_RST;
            interrupt_request_out_n_r <= 1'b1;
        end else begin
            interrupt_group_summary_r <= summary_nxt;
            rd_data_r <= rd_data_nxt;
            interrupt_request_out_n_r <= interrupt_request_out_n_nxt;
        end
    end

endmodule : igss_summary_status

//--- test/igss_chk.sv
// Checker for the interrupt group summary status block
module igss_chk (
    input wire logic ref_clk, nrst, reset_complete_event, conversion_busy_status, rd_en,
    input wire igss_pkg::igss_ext_flags_t ext_flags,
    input wire igss_pkg::igss_mask_t flag_mask,
    input wire igss_pkg::igss_pin_cfg_t pin_cfg,
    input wire logic [7:0] rd_addr, rd_data_r, interrupt_group_summary_r,
    input wire logic reset_done_flag_r, conversion_ready_flag_r, interrupt_request_out_n_r
);
    logic [21:0] e;
    logic [7:0] g, s;
    logic irq;
    assign e = ext_flags;
    assign s = interrupt_group_summary_r;
    assign g = {|e[2:0], |(e[4:3] & pin_cfg), |e[6:5], e[7], |e[10:8],
        |e[12:11] | conversion_ready_flag_r, |e[16:13], |e[21:17] | reset_done_flag_r};
    assign irq = |(e & ~flag_mask.ext) | (reset_done_flag_r & ~flag_mask.reset_done_flag)
        | (conversion_ready_flag_r & ~flag_mask.conversion_ready_flag);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    AST_PWR: assert property (s[0] == $past(g[0])) else $error("bit0");
    AST_AMP: assert property (s[1] == $past(g[1])) else $error("bit1");
    AST_CNV: assert property (s[2] == $past(g[2])) else $error("bit2");
    AST_PIN: assert property (s[6] == $past(g[6])) else $error("bit6");
    AST_OTH: assert property ({s[7], s[5:3]} == $past({g[7], g[5:3]})) else $error("oth");
    AST_RD: assert property (rd_en && rd_addr == 8'h00 |=> rd_data_r == s) else $error("rd");
    AST_RDN: assert property (rd_en && rd_addr != 8'h00 |=> rd_data_r == 8'h00) else $error("rdn");
    AST_RSD: assert property ($rose(reset_complete_event) |=> reset_done_flag_r) else $error("rs");
    AST_CRD: assert property ($fell(conversion_busy_status) |=> conversion_ready_flag_r) else $error("cr");
    AST_IRQ: assert property (interrupt_request_out_n_r == !$past(irq)) else $error("irq");
    cover property (s[6]);
    cover property ($fell(conversion_busy_status));
    cover property (!interrupt_request_out_n_r);
endmodule : igss_chk

bind igss_summary_status igss_chk u_chk (.*);

//--- test/testbench.sv
// Self-checking bench for the interrupt group summary status block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, nrst = 0, reset_complete_event = 0, conversion_busy_status = 0;
    logic reset_done_clear = 0, conversion_ready_clear = 0, rd_en = 0;
    igss_pkg::igss_ext_flags_t ext_flags = '0;
    igss_pkg::igss_mask_t flag_mask = '0;
    igss_pkg::igss_pin_cfg_t pin_cfg = 2'h3;
    logic [7:0] rd_addr = 8'h00, rd_data_r, interrupt_group_summary_r;
    logic reset_done_flag_r, conversion_ready_flag_r, interrupt_request_out_n_r;
    int error_cnt = 0, num_checks = 0;
    always #4 ref_clk = ~ref_clk;
    igss_summary_status DUT (.*);
    task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
        num_checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic rd(logic [7:0] a, logic [7:0] ex);
        rd_en = 1;
        rd_addr = a;
        @(negedge ref_clk);
        rd_en = 0;
        chk("rd", ex, rd_data_r);
    endtask : rd
    function automatic logic [2:0] grp(int i);
        return i > 16 ? 3'h0 : i > 12 ? 3'h1 : i > 10 ? 3'h2 : i > 7 ? 3'h3 :
            i == 7 ? 3'h4 : i > 4 ? 3'h5 : i > 2 ? 3'h6 : 3'h7;
    endfunction : grp
    task automatic t_groups();
        for (int i = 0; i < 22; i++) begin
            ext_flags = 22'h1 << i;
            flag_mask = '0;
            rd(8'h00, 8'h1 << grp(i));
            chk("irq", 8'h0, interrupt_request_out_n_r);
            flag_mask.ext = '1;
            @(negedge ref_clk);
            chk("irq", 8'h1, interrupt_request_out_n_r);
        end
        ext_flags = '0;
        rd(8'h00, 8'h00);
    endtask : t_groups
    task automatic t_pin();
        pin_cfg = 2'h0;
        flag_mask = '0;
        ext_flags = 22'h18;
        rd(8'h00, 8'h00);
        chk("irq", 8'h0, interrupt_request_out_n_r);
        pin_cfg = 2'h2;
        ext_flags = 22'h08;
        rd(8'h00, 8'h00);
        ext_flags = '0;
    endtask : t_pin
    task automatic t_events();
        reset_complete_event = 1;
        conversion_busy_status = 1;
        repeat (3) @(negedge ref_clk);
        chk("rdf", 8'h1, reset_done_flag_r);
        rd(8'h00, 8'h01);
        reset_done_clear = 1;
        conversion_busy_status = 0;
        @(negedge ref_clk);
        reset_done_clear = 0;
        chk("rdf", 8'h0, reset_done_flag_r);
        repeat (2) @(negedge ref_clk);
        rd(8'h00, 8'h04);
        rd(8'h01, 8'h00);
    endtask : t_events
    task automatic t_clear();
        flag_mask = '1;
        conversion_ready_clear = 1;
        @(negedge ref_clk);
        conversion_ready_clear = 0;
        chk("crf", 8'h0, conversion_ready_flag_r);
        chk("irq", 8'h1, interrupt_request_out_n_r);
        reset_complete_event = 0;
        conversion_busy_status = 1;
        @(negedge ref_clk);
        reset_complete_event = 1;
        conversion_busy_status = 0;
        reset_done_clear = 1;
        conversion_ready_clear = 1;
        @(negedge ref_clk);
        reset_done_clear = 0;
        conversion_ready_clear = 0;
        chk("rdf", 8'h1, reset_done_flag_r);
        chk("crf", 8'h1, conversion_ready_flag_r);
        @(negedge ref_clk);
        chk("sum", 8'h05, interrupt_group_summary_r);
        chk("irq", 8'h1, interrupt_request_out_n_r);
        flag_mask.reset_done_flag = 0;
        @(negedge ref_clk);
        chk("irq", 8'h0, interrupt_request_out_n_r);
        reset_done_clear = 1;
        conversion_ready_clear = 1;
        @(negedge ref_clk);
        reset_done_clear = 0;
        conversion_ready_clear = 0;
        @(negedge ref_clk);
        chk("sum", 8'h00, interrupt_group_summary_r);
        chk("irq", 8'h1, interrupt_request_out_n_r);
    endtask : t_clear
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    initial begin
        repeat (4) @(negedge ref_clk);
        nrst = 1;
        @(negedge ref_clk);
        chk("irq", 8'h1, interrupt_request_out_n_r);
        rd(8'h00, 8'h00);
        t_groups();
        t_pin();
        t_events();
        t_clear();
        end_sim();
    end
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end
endmodule : testbench
